// ===== sr_params.svh
// Constants shared by the segmentation and reassembly block
`ifndef SR_PARAMS_SVH
`define SR_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SR_MAX_SEG_BYTES 256
`define SR_MAX_PAYLOAD 8'hff
`define SR_MAX_COUNT 16'd63
`define SR_MAX_UNIT_BYTES (63 * `SR_MAX_SEG_BYTES)
`define SR_LAST_CALC_SEG 7'h3f

// ----------------------------------------
// Header layout and kind codes
// ----------------------------------------
`define SR_KIND_MSB 7
`define SR_KIND_LSB 6
`define SR_FIELD_MSB 5
`define SR_FIELD_LSB 0
`define SR_KIND_FIRST 2'h0
`define SR_KIND_MID 2'h1
`define SR_KIND_LAST 2'h2
`define SR_KIND_RSVD 2'h3

`endif

// ===== sr_pkg.sv
// Types of the segmentation and reassembly block
package sr_pkg;
	typedef logic [7:0] sr_byte_type;
	typedef logic [2:0] sr_prim_code_type;
	typedef logic [1:0] sr_prim_phase_type;
	typedef enum logic [1:0] {TX_IDLE, TX_CALC, TX_HDR, TX_PAY} sr_tx_state_type;
	typedef enum logic [1:0] {RX_HDR, RX_PAY, RX_SKIP, RX_DELIV} sr_rx_state_type;
endpackage

// ===== sr_prim_if.sv
// Carrier for one service primitive between the top and the mapper
interface sr_prim_if #(parameter int W = 32);
	logic valid;
	sr_pkg::sr_prim_code_type code;
	sr_pkg::sr_prim_phase_type phase;
	logic [W-1:0] param;
	modport src (output valid, output code, output phase, output param);
	modport dst (input valid, input code, input phase, input param);
endinterface

// ===== sr_prim_map.sv
// One-cycle registered pass-through for service primitives
module sr_prim_map (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Primitive in and out
	sr_prim_if.dst from_side,
	sr_prim_if.src to_side
);
	// Copy kind, phase and parameters untouched
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			to_side.valid <= 1'b0;
			to_side.code <= '0;
			to_side.phase <= '0;
			to_side.param <= '0;
		end
		else
		begin
			to_side.valid <= from_side.valid;
			if (from_side.valid)
			begin
				to_side.code <= from_side.code;
				to_side.phase <= from_side.phase;
				to_side.param <= from_side.param;
			end
		end
	end

	// Nothing altered on the way through
	chk_prim_unchanged: assert property (@(posedge clk_i) disable iff (reset_i)
		from_side.valid |=> to_side.valid && to_side.param == $past(from_side.param)
		&& to_side.code == $past(from_side.code) && to_side.phase == $past(from_side.phase))
		else $error("primitive changed in transit");
endmodule

// ===== sr_segmentation_reassembly.sv
// Segmentation, reassembly and transparent primitive path
`include "sr_params.svh"
module sr_segmentation_reassembly #(
	parameter int PRIM_W = 32,
	parameter int UNIT_AW = 14,
	parameter int MAX_UNIT = `SR_MAX_UNIT_BYTES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Unit to send, from the upper layer
	input wire logic tx_start_i,
	input wire logic [UNIT_AW-1:0] tx_len_i,
	input wire logic [7:0] tx_seg_size_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic tx_busy_o,
	output logic tx_reject_o,
	// Segments to the MAC
	output logic mac_tx_valid_o,
	output logic [7:0] mac_tx_data_o,
	output logic mac_tx_last_o,
	input wire logic mac_tx_ready_i,
	input wire logic local_aggr_i,
	input wire logic peer_aggr_i,
	output logic mac_tx_aggr_o,
	// Segments from the MAC
	input wire logic mac_rx_valid_i,
	input wire logic [7:0] mac_rx_data_i,
	input wire logic mac_rx_last_i,
	output logic mac_rx_ready_o,
	// Reassembled units to the upper layer
	output logic up_rx_valid_o,
	output logic [7:0] up_rx_data_o,
	output logic up_rx_last_o,
	input wire logic up_rx_ready_i,
	output logic rx_drop_o,
	// Primitives from upper layer toward MAC
	input wire logic up_prim_valid_i,
	input wire logic [2:0] up_prim_code_i,
	input wire logic [1:0] up_prim_phase_i,
	input wire logic [PRIM_W-1:0] up_prim_param_i,
	output logic mac_prim_valid_o,
	output logic [2:0] mac_prim_code_o,
	output logic [1:0] mac_prim_phase_o,
	output logic [PRIM_W-1:0] mac_prim_param_o,
	// Primitives from MAC toward upper layer
	input wire logic mac_prim_valid_i,
	input wire logic [2:0] mac_prim_code_i,
	input wire logic [1:0] mac_prim_phase_i,
	input wire logic [PRIM_W-1:0] mac_prim_param_i,
	output logic up_prim_valid_o,
	output logic [2:0] up_prim_code_o,
	output logic [1:0] up_prim_phase_o,
	output logic [PRIM_W-1:0] up_prim_param_o
);
	// ----------------------------------------
	// Header builder
	// ----------------------------------------
	// Count less one on the first segment, sequence number on all others
	function automatic sr_pkg::sr_byte_type sr_hdr(input logic [6:0] no, input logic [6:0] total);
		logic [6:0] cm1;
		logic [6:0] sm1;
		cm1 = total - 7'h1;
		sm1 = no - 7'h1;
		if (no == 7'h0)
			sr_hdr = {`SR_KIND_FIRST, cm1[5:0]};
		else if (no == cm1)
			sr_hdr = {`SR_KIND_LAST, sm1[5:0]};
		else
			sr_hdr = {`SR_KIND_MID, sm1[5:0]};
	endfunction

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	sr_pkg::sr_tx_state_type tstate;
	logic [UNIT_AW-1:0] unit_len;
	logic [UNIT_AW-1:0] rem;
	logic [UNIT_AW-1:0] bytes_left;
	logic [7:0] pay_size;
	logic [7:0] seg_left;
	logic [6:0] seg_total;
	logic [6:0] seg_no;
	logic out_hdr;

	// Decoding of the transmit step
	wire [7:0] req_size = (tx_seg_size_i == 8'h0) ? `SR_MAX_PAYLOAD : tx_seg_size_i;
	wire len_ok = tx_len_i != '0 && tx_len_i <= UNIT_AW'(MAX_UNIT);
	wire start_ok = tstate == sr_pkg::TX_IDLE && tx_start_i && len_ok;
	wire [UNIT_AW-1:0] pay_wide = UNIT_AW'(pay_size);
	wire calc_fits = rem <= pay_wide;
	wire calc_over = seg_total == `SR_LAST_CALC_SEG && !calc_fits;
	wire [7:0] seg_take = (bytes_left < pay_wide) ? bytes_left[7:0] : pay_size;
	wire load_ok = !mac_tx_valid_o || mac_tx_ready_i;
	wire tx_accept = tx_valid_i && tx_ready_o;
	wire pay_end_seg = seg_left == 8'h1;
	wire pay_end_unit = bytes_left == UNIT_AW'(1);
	assign tx_ready_o = tstate == sr_pkg::TX_PAY && load_ok;
	assign tx_busy_o = tstate != sr_pkg::TX_IDLE;

	// Sequencer; the count is found by repeated subtraction, trading cycles for no divider
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tstate <= sr_pkg::TX_IDLE;
			unit_len <= '0;
			rem <= '0;
			bytes_left <= '0;
			pay_size <= `SR_MAX_PAYLOAD;
			seg_left <= 8'h0;
			seg_total <= 7'h0;
			seg_no <= 7'h0;
		end
		else
		begin
			unique case (tstate)
				sr_pkg::TX_IDLE:
				begin
					if (start_ok)
					begin
						unit_len <= tx_len_i;
						rem <= tx_len_i;
						bytes_left <= tx_len_i;
						pay_size <= req_size;
						seg_total <= 7'h0;
						seg_no <= 7'h0;
						tstate <= sr_pkg::TX_CALC;
					end
				end
				sr_pkg::TX_CALC:
				begin
					if (calc_fits)
					begin
						seg_total <= seg_total + 7'h1;
						tstate <= sr_pkg::TX_HDR;
					end
					else if (calc_over)
					begin
						// Too many segments at the asked size: fall back to the largest
						pay_size <= `SR_MAX_PAYLOAD;
						rem <= unit_len;
						seg_total <= 7'h0;
					end
					else
					begin
						rem <= rem - pay_wide;
						seg_total <= seg_total + 7'h1;
					end
				end
				sr_pkg::TX_HDR:
				begin
					if (load_ok)
					begin
						seg_left <= seg_take;
						tstate <= sr_pkg::TX_PAY;
					end
				end
				sr_pkg::TX_PAY:
				begin
					if (tx_accept)
					begin
						bytes_left <= bytes_left - UNIT_AW'(1);
						seg_left <= seg_left - 8'h1;
						if (pay_end_seg)
						begin
							seg_no <= seg_no + 7'h1;
							tstate <= pay_end_unit ? sr_pkg::TX_IDLE : sr_pkg::TX_HDR;
						end
					end
				end
			endcase
		end
	end

	// Output stage toward the MAC; a header always leads each segment
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mac_tx_valid_o <= 1'b0;
			mac_tx_data_o <= 8'h0;
			mac_tx_last_o <= 1'b0;
			out_hdr <= 1'b0;
			tx_reject_o <= 1'b0;
			mac_tx_aggr_o <= 1'b0;
		end
		else
		begin
			tx_reject_o <= tstate == sr_pkg::TX_IDLE && tx_start_i && !len_ok;
			mac_tx_aggr_o <= local_aggr_i && peer_aggr_i;
			if (load_ok)
			begin
				mac_tx_valid_o <= tstate == sr_pkg::TX_HDR || tx_accept;
				out_hdr <= tstate == sr_pkg::TX_HDR;
				mac_tx_last_o <= tx_accept && pay_end_seg;
				mac_tx_data_o <= (tstate == sr_pkg::TX_HDR) ? sr_hdr(seg_no, seg_total) : tx_data_i;
			end
		end
	end

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	sr_pkg::sr_rx_state_type rstate;
	logic [7:0] unit_mem [0:MAX_UNIT-1];
	logic unit_open;
	logic seg_final;
	logic [5:0] r_cnt;
	logic [5:0] seq_exp;
	logic [UNIT_AW-1:0] wr_ptr;
	logic [UNIT_AW-1:0] rd_ptr;
	logic [UNIT_AW-1:0] dlen;

	// Header and payload checks
	wire [1:0] rx_kind = mac_rx_data_i[`SR_KIND_MSB:`SR_KIND_LSB];
	wire [5:0] rx_field = mac_rx_data_i[`SR_FIELD_MSB:`SR_FIELD_LSB];
	wire rx_take = mac_rx_valid_i && mac_rx_ready_o;
	wire hdr_first = rx_kind == `SR_KIND_FIRST;
	wire [5:0] cnt_m1 = r_cnt - 6'h1;
	wire hdr_next_ok = unit_open && rx_kind != `SR_KIND_RSVD && rx_field == seq_exp && r_cnt != 6'h0
		&& ((rx_kind == `SR_KIND_LAST) ? rx_field == cnt_m1 : rx_field < cnt_m1);
	wire hdr_ok = (hdr_first || hdr_next_ok) && !mac_rx_last_i;
	wire hdr_final = hdr_first ? rx_field == 6'h0 : rx_kind == `SR_KIND_LAST;
	wire mem_full = wr_ptr == UNIT_AW'(MAX_UNIT);
	wire uload = !up_rx_valid_o || up_rx_ready_i;
	wire deliv_more = rd_ptr != dlen;
	assign mac_rx_ready_o = rstate != sr_pkg::RX_DELIV;

	// Segment buffer, no reset needed for storage
	always_ff @(posedge clk_i)
	begin
		if (rstate == sr_pkg::RX_PAY && rx_take && !mem_full)
			unit_mem[wr_ptr] <= mac_rx_data_i;
	end

	// Reassembly sequencer
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rstate <= sr_pkg::RX_HDR;
			unit_open <= 1'b0;
			seg_final <= 1'b0;
			r_cnt <= 6'h0;
			seq_exp <= 6'h0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			dlen <= '0;
			rx_drop_o <= 1'b0;
		end
		else
		begin
			rx_drop_o <= 1'b0;
			unique case (rstate)
				sr_pkg::RX_HDR:
				begin
					if (rx_take)
					begin
						// A new first segment abandons any unit still open
						rx_drop_o <= (unit_open && hdr_first) || !hdr_ok;
						seg_final <= hdr_final;
						if (hdr_ok && hdr_first)
						begin
							r_cnt <= rx_field;
							seq_exp <= 6'h0;
							wr_ptr <= '0;
							unit_open <= 1'b1;
							rstate <= sr_pkg::RX_PAY;
						end
						else if (hdr_ok)
						begin
							seq_exp <= seq_exp + 6'h1;
							rstate <= sr_pkg::RX_PAY;
						end
						else
						begin
							unit_open <= 1'b0;
							rstate <= mac_rx_last_i ? sr_pkg::RX_HDR : sr_pkg::RX_SKIP;
						end
					end
				end
				sr_pkg::RX_PAY:
				begin
					if (rx_take && mem_full)
					begin
						// Too many bytes: the unit can no longer be whole
						rx_drop_o <= 1'b1;
						unit_open <= 1'b0;
						rstate <= mac_rx_last_i ? sr_pkg::RX_HDR : sr_pkg::RX_SKIP;
					end
					else if (rx_take)
					begin
						wr_ptr <= wr_ptr + UNIT_AW'(1);
						if (mac_rx_last_i && seg_final)
						begin
							unit_open <= 1'b0;
							dlen <= wr_ptr + UNIT_AW'(1);
							rd_ptr <= '0;
							rstate <= sr_pkg::RX_DELIV;
						end
						else if (mac_rx_last_i)
							rstate <= sr_pkg::RX_HDR;
					end
				end
				sr_pkg::RX_SKIP:
				begin
					if (rx_take && mac_rx_last_i)
						rstate <= sr_pkg::RX_HDR;
				end
				sr_pkg::RX_DELIV:
				begin
					if (uload && deliv_more)
						rd_ptr <= rd_ptr + UNIT_AW'(1);
					else if (uload)
						rstate <= sr_pkg::RX_HDR;
				end
			endcase
		end
	end

	// Delivery stage toward the upper layer
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			up_rx_valid_o <= 1'b0;
			up_rx_data_o <= 8'h0;
			up_rx_last_o <= 1'b0;
		end
		else if (uload)
		begin
			up_rx_valid_o <= rstate == sr_pkg::RX_DELIV && deliv_more;
			up_rx_data_o <= unit_mem[rd_ptr];
			up_rx_last_o <= rd_ptr == dlen - UNIT_AW'(1);
		end
	end

	// ----------------------------------------
	// Transparent primitive path
	// ----------------------------------------
	sr_prim_if #(.W(PRIM_W)) down_in ();
	sr_prim_if #(.W(PRIM_W)) down_out ();
	sr_prim_if #(.W(PRIM_W)) up_in ();
	sr_prim_if #(.W(PRIM_W)) up_out ();

	// Port bundling, both directions
	assign down_in.valid = up_prim_valid_i;
	assign down_in.code = up_prim_code_i;
	assign down_in.phase = up_prim_phase_i;
	assign down_in.param = up_prim_param_i;
	assign mac_prim_valid_o = down_out.valid;
	assign mac_prim_code_o = down_out.code;
	assign mac_prim_phase_o = down_out.phase;
	assign mac_prim_param_o = down_out.param;
	assign up_in.valid = mac_prim_valid_i;
	assign up_in.code = mac_prim_code_i;
	assign up_in.phase = mac_prim_phase_i;
	assign up_in.param = mac_prim_param_i;
	assign up_prim_valid_o = up_out.valid;
	assign up_prim_code_o = up_out.code;
	assign up_prim_phase_o = up_out.phase;
	assign up_prim_param_o = up_out.param;

	sr_prim_map u_down (.clk_i(clk_i), .reset_i(reset_i), .from_side(down_in), .to_side(down_out));
	sr_prim_map u_up (.clk_i(clk_i), .reset_i(reset_i), .from_side(up_in), .to_side(up_out));

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Helpers: bytes in the current outgoing segment, last header sent, beats delivered
	logic [8:0] out_cnt;
	logic [7:0] prev_hdr;
	logic [UNIT_AW-1:0] del_cnt;
	wire out_fire = mac_tx_valid_o && mac_tx_ready_i;
	wire up_fire = up_rx_valid_o && up_rx_ready_i;
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			out_cnt <= 9'h0;
			prev_hdr <= 8'h0;
			del_cnt <= '0;
		end
		else
		begin
			if (out_fire)
				out_cnt <= mac_tx_last_o ? 9'h0 : out_cnt + 9'h1;
			if (out_fire && out_hdr)
				prev_hdr <= mac_tx_data_o;
			if (up_fire)
				del_cnt <= up_rx_last_o ? '0 : del_cnt + UNIT_AW'(1);
		end
	end

	chk_no_reserved_kind: assert property (mac_tx_valid_o && out_hdr |->
		mac_tx_data_o[`SR_KIND_MSB:`SR_KIND_LSB] != `SR_KIND_RSVD)
		else $error("reserved segment kind sent");
	chk_seg_size_max: assert property (out_fire |-> out_cnt < 9'(`SR_MAX_SEG_BYTES))
		else $error("segment longer than limit");
	chk_one_header: assert property (out_fire && out_cnt == 9'h0 |-> out_hdr)
		else $error("segment does not start with one header");
	chk_hdr_once: assert property (out_fire && out_cnt != 9'h0 |-> !out_hdr)
		else $error("second header inside a segment");
	chk_seq_step: assert property (out_fire && out_hdr && mac_tx_data_o[7:6] != `SR_KIND_FIRST
		&& prev_hdr[7:6] != `SR_KIND_FIRST |-> mac_tx_data_o[5:0] == prev_hdr[5:0] + 6'h1)
		else $error("sequence number did not step by one");
	chk_first_seq_zero: assert property (out_fire && out_hdr && mac_tx_data_o[7:6] != `SR_KIND_FIRST
		&& prev_hdr[7:6] == `SR_KIND_FIRST |-> mac_tx_data_o[5:0] == 6'h0)
		else $error("first sequence number not zero");
	chk_count_zero_alone: assert property (out_fire && out_hdr && prev_hdr == 8'h0 |->
		mac_tx_data_o[7:6] == `SR_KIND_FIRST)
		else $error("segment after a single-segment unit");
	// A fallback recount can run the count phase twice, so allow two full passes
	chk_long_unit_cut: assert property ($rose(tx_busy_o) && unit_len > UNIT_AW'(255) |=>
		##[1:140] tstate == sr_pkg::TX_HDR && seg_total > 7'h1)
		else $error("long unit not segmented");
	chk_unit_limit: assert property (tstate == sr_pkg::TX_IDLE && tx_start_i
		&& tx_len_i > UNIT_AW'(MAX_UNIT) |=> tx_reject_o && !tx_busy_o)
		else $error("oversized unit not refused");
	chk_drop_no_deliver: assert property (rx_drop_o |-> !up_rx_valid_o)
		else $error("partial unit delivered");
	chk_deliver_whole: assert property (up_fire && up_rx_last_o |->
		del_cnt + UNIT_AW'(1) == dlen)
		else $error("delivered unit length wrong");
endmodule

// ===== sr_mac_model.sv
// MAC-side sink model that takes the segment stream
module sr_mac_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Segment stream from the block
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	input wire logic last_i,
	output logic ready_o,
	// Test control
	input wire logic stall_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase;
	logic [8:0] got[$];
	// Stalling passes one cycle in four, so the block must hold its byte
	assign ready_o = !stall_i || (phase == 2'h0);
	// Record each byte, with its end-of-segment flag, as it is taken
	always @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			phase <= 2'h0;
		else
		begin
			phase <= phase + 2'h1;
			if (valid_i && ready_o)
				got.push_back({last_i, data_i});
		end
	end
endmodule

// ===== sr_segmentation_reassembly_bench.sv
// Self-checking bench for the segmentation and reassembly block
`include "sr_params.svh"
module sr_segmentation_reassembly_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic tx_start_i = 1'b0;
	logic [13:0] tx_len_i = 14'h0;
	logic [7:0] tx_seg_size_i = 8'h0;
	logic tx_valid_i = 1'b1;
	logic [7:0] tx_data_i = 8'h5a;
	logic tx_ready_o, tx_busy_o, tx_reject_o;
	logic mac_tx_valid_o, mac_tx_last_o, mac_tx_ready_i, mac_tx_aggr_o;
	logic [7:0] mac_tx_data_o;
	logic local_aggr_i = 1'b0;
	logic peer_aggr_i = 1'b0;
	logic mac_rx_valid_i = 1'b0;
	logic [7:0] mac_rx_data_i = 8'h0;
	logic mac_rx_last_i = 1'b0;
	logic mac_rx_ready_o, up_rx_valid_o, up_rx_last_o, rx_drop_o;
	logic [7:0] up_rx_data_o;
	logic up_rx_ready_i = 1'b0;
	logic up_prim_valid_i = 1'b0;
	logic mac_prim_valid_i = 1'b0;
	logic [2:0] up_prim_code_i = 3'h0;
	logic [2:0] mac_prim_code_i = 3'h0;
	logic [1:0] up_prim_phase_i = 2'h0;
	logic [1:0] mac_prim_phase_i = 2'h0;
	logic [31:0] up_prim_param_i = 32'h0;
	logic [31:0] mac_prim_param_i = 32'h0;
	logic mac_prim_valid_o, up_prim_valid_o;
	logic [2:0] mac_prim_code_o, up_prim_code_o;
	logic [1:0] mac_prim_phase_o, up_prim_phase_o;
	logic [31:0] mac_prim_param_o, up_prim_param_o;
	logic stall = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int tx_idx = 0;
	int drops = 0;
	int drops_seen = 0;
	int up_seen = 0;
	logic [8:0] up_q[$];

	always #10 clk_i = ~clk_i;

	sr_segmentation_reassembly #(.PRIM_W(32)) dut (.clk_i, .reset_i, .tx_start_i, .tx_len_i,
		.tx_seg_size_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .tx_busy_o, .tx_reject_o,
		.mac_tx_valid_o, .mac_tx_data_o, .mac_tx_last_o, .mac_tx_ready_i, .local_aggr_i,
		.peer_aggr_i, .mac_tx_aggr_o, .mac_rx_valid_i, .mac_rx_data_i, .mac_rx_last_i,
		.mac_rx_ready_o, .up_rx_valid_o, .up_rx_data_o, .up_rx_last_o, .up_rx_ready_i,
		.rx_drop_o, .up_prim_valid_i, .up_prim_code_i, .up_prim_phase_i, .up_prim_param_i,
		.mac_prim_valid_o, .mac_prim_code_o, .mac_prim_phase_o, .mac_prim_param_o,
		.mac_prim_valid_i, .mac_prim_code_i, .mac_prim_phase_i, .mac_prim_param_i,
		.up_prim_valid_o, .up_prim_code_o, .up_prim_phase_o, .up_prim_param_o);

	sr_mac_model mac (.clk_i(clk_i), .reset_i(reset_i), .valid_i(mac_tx_valid_o),
		.data_i(mac_tx_data_o), .last_i(mac_tx_last_o), .ready_o(mac_tx_ready_i),
		.stall_i(stall));

	// Payload pattern, so a dropped or repeated byte shows up
	function automatic logic [7:0] pat(input int i);
		return i[7:0] ^ 8'h5a;
	endfunction

	// Feeder with a gap after each byte when slow, upper-layer sink with stalls, drop counter
	always @(posedge clk_i)
	begin
		up_rx_ready_i <= ~up_rx_ready_i;
		tx_valid_i <= !(stall && tx_valid_i && tx_ready_o);
		if (tx_start_i)
		begin
			tx_idx <= 0;
			tx_data_i <= pat(0);
		end
		else if (tx_valid_i && tx_ready_o)
		begin
			tx_idx <= tx_idx + 1;
			tx_data_i <= pat(tx_idx + 1);
		end
		if (up_rx_valid_o === 1'b1 && up_rx_ready_i)
			up_q.push_back({up_rx_last_o, up_rx_data_o});
		if (rx_drop_o === 1'b1)
			drops <= drops + 1;
	end

	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic check(input logic ok, input string msg);
	begin
		n_tests++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[ERR] %0t %s", $time, msg);
		end
	end
	endtask

	task automatic wrap_up;
	begin
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// Holds a byte until the block is ready; taken at the next edge
	task automatic rx_byte(input logic [7:0] b, input logic l);
	begin
		@(posedge clk_i);
		mac_rx_valid_i <= 1'b1;
		mac_rx_data_i <= b;
		mac_rx_last_i <= l;
		#1;
		while (mac_rx_ready_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
	end
	endtask

	task automatic rx_seg(input logic [7:0] hdr, input int n, input logic [7:0] base);
	begin
		rx_byte(hdr, n == 0);
		for (int j = 0; j < n; j++)
			rx_byte(base + 8'(j), j == n - 1);
	end
	endtask

	// Idle line shows the inverse of the last byte, not a stale copy
	task automatic rx_idle;
	begin
		@(posedge clk_i);
		mac_rx_valid_i <= 1'b0;
		mac_rx_data_i <= ~mac_rx_data_i;
	end
	endtask

	task automatic rx_done(input int nb, input int nd);
	begin
		rx_idle();
		repeat (20) @(posedge clk_i);
		#1;
		check(up_q.size() - up_seen == nb && drops - drops_seen == nd, "reassembly outcome");
		for (int i = up_seen; i < up_q.size(); i++)
			check(up_q[i] === {i == up_q.size() - 1, 8'h10 + 8'(i - up_seen)}, "reassembled byte");
		up_seen = up_q.size();
		drops_seen = drops;
	end
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic run_tx(input int len, input int p, input logic slow);
		int n, pay, left, cnt, lim;
		logic [8:0] exp[$];
	begin
		pay = (p == 0) ? 255 : p;
		n = (len + pay - 1) / pay;
		if (n > 64)
		begin
			pay = 255;
			n = (len + 254) / 255;
		end
		left = len;
		for (int k = 0; k < n; k++)
		begin
			if (k == 0)
				exp.push_back({1'b0, `SR_KIND_FIRST, 6'(n - 1)});
			else
				exp.push_back({1'b0, (k == n - 1) ? `SR_KIND_LAST : `SR_KIND_MID, 6'(k - 1)});
			cnt = (left < pay) ? left : pay;
			for (int j = 0; j < cnt; j++)
				exp.push_back({j == cnt - 1, pat(len - left + j)});
			left -= cnt;
		end
		mac.got.delete();
		@(posedge clk_i);
		stall <= slow;
		tx_start_i <= 1'b1;
		tx_len_i <= 14'(len);
		tx_seg_size_i <= 8'(p);
		@(posedge clk_i);
		tx_start_i <= 1'b0;
		#1;
		lim = 0;
		while ((tx_busy_o !== 1'b0 || mac.got.size() < exp.size()) && lim < len * 8 + 500)
		begin
			@(posedge clk_i);
			#1;
			lim++;
		end
		check(tx_busy_o === 1'b0 && lim < len * 8 + 500, "unit not finished in time");
		check(mac.got.size() == exp.size(), "segment stream length");
		foreach (exp[i])
			if (i < mac.got.size())
				check(mac.got[i] === exp[i], $sformatf("stream byte %0d", i));
		$display("tx test len %0d size %0d done", len, p);
	end
	endtask

	task automatic test_reject(input int len);
	begin
		@(posedge clk_i);
		tx_start_i <= 1'b1;
		tx_len_i <= 14'(len);
		@(posedge clk_i);
		tx_start_i <= 1'b0;
		#1;
		check(tx_reject_o === 1'b1 && tx_busy_o === 1'b0, "bad length accepted");
		@(posedge clk_i);
		#1;
		check(tx_reject_o === 1'b0, "refusal pulse too long");
		$display("reject test len %0d done", len);
	end
	endtask

	task automatic test_rx;
	begin
		rx_seg(8'h01, 2, 8'h10);
		rx_idle();
		repeat (6) @(posedge clk_i);
		#1;
		check(up_q.size() == up_seen, "partial unit delivered early");
		rx_seg(8'h80, 1, 8'h12);
		rx_done(3, 0);
		rx_seg(8'h02, 1, 8'h10);
		rx_seg(8'h81, 1, 8'h11);
		rx_done(0, 1);
		rx_seg(8'hc0, 1, 8'h10);
		rx_done(0, 1);
		rx_seg(8'h00, 1, 8'h10);
		rx_seg(8'h40, 1, 8'h11);
		rx_done(1, 1);
		rx_seg(8'h01, 1, 8'h10);
		rx_seg(8'h00, 1, 8'h10);
		rx_done(1, 1);
		rx_seg(8'h00, 0, 8'h10);
		rx_done(0, 1);
		$display("rx test done");
	end
	endtask

	task automatic test_prim;
	begin
		for (int i = 0; i < 32; i++)
		begin
			@(posedge clk_i);
			up_prim_valid_i <= 1'b1;
			up_prim_code_i <= 3'(i);
			up_prim_phase_i <= 2'(i >> 3);
			up_prim_param_i <= 32'h1234_0000 + 32'(i);
			mac_prim_valid_i <= 1'b1;
			mac_prim_code_i <= ~3'(i);
			mac_prim_phase_i <= 2'(i);
			mac_prim_param_i <= ~32'(i);
			@(posedge clk_i);
			up_prim_valid_i <= 1'b0;
			mac_prim_valid_i <= 1'b0;
			#1;
			check(mac_prim_valid_o === 1'b1 && mac_prim_code_o === 3'(i) &&
				mac_prim_phase_o === 2'(i >> 3) &&
				mac_prim_param_o === 32'h1234_0000 + 32'(i), "primitive to MAC");
			check(up_prim_valid_o === 1'b1 && up_prim_code_o === ~3'(i) &&
				up_prim_phase_o === 2'(i) && up_prim_param_o === ~32'(i), "primitive up");
		end
		$display("primitive test done");
	end
	endtask

	task automatic test_aggr;
	begin
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			local_aggr_i <= i[0];
			peer_aggr_i <= i[1];
			@(posedge clk_i);
			#1;
			check(mac_tx_aggr_o === (i == 3), "aggregation advertisement");
		end
		$display("aggregation test done");
	end
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		test_aggr();
		run_tx(5, 2, 1'b1);
		run_tx(300, 0, 1'b0);
		run_tx(1, 0, 1'b1);
		run_tx(100, 1, 1'b0);
		run_tx(`SR_MAX_UNIT_BYTES, 0, 1'b0);
		test_reject(0);
		test_reject(`SR_MAX_UNIT_BYTES + 1);
		test_rx();
		test_prim();
		wrap_up();
	end

	// Watchdog: the run needs some 20k cycles, so 100k means a hang
	initial
	begin
		#(100000 * 20);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
